// *** verilog/fsbsb_pkg.sv ***
// shared constants for the sideband lock, error and interrupt pin ends
package fsbsb_pkg;
    // local interrupt pin lanes
    localparam int         IRQ_W         = 2;
    localparam int         IRQ_MASKABLE  = 0;
    localparam int         IRQ_NMI       = 1;
    // pin synchroniser depth
    localparam int         SYNC_STAGES   = 3;
    // reset state of the local interrupt controller enable
    localparam logic       LIC_EN_RST    = 1'h1;
    // machine check error drive length in bus clocks
    localparam int         MC_CNT_W      = 2;
    localparam logic [1:0] MC_PULSE      = 2'h2;
    localparam logic [1:0] MC_ZERO       = 2'h0;
    localparam logic [1:0] MC_ONE        = 2'h1;
endpackage

// *** verilog/fsbsb_if.sv ***
// sideband pins between the bus agent and the system side, with wire resolution
`timescale 1ns/1ps
interface fsbsb_if;
    // interrupt pins, driven by the system side only
    logic [1:0] local_irq_pins;
    // priority request, driven by the system side only
    logic       priority_agent_bus_request_n;
    // internal fault, driven by the agent only
    logic       internal_fault_n;
    // open-drain lock: per-end output and enable
    logic       dev_lock_n_o;
    logic       dev_lock_oe;
    logic       oth_lock_n_o;
    logic       oth_lock_oe;
    // open-drain machine check error: per-end output and enable
    logic       dev_machine_check_error_n_n_o;
    logic       dev_machine_check_error_n_oe;
    logic       oth_machine_check_error_n_n_o;
    logic       oth_machine_check_error_n_oe;
    // resolved wire levels, pulled high when nobody drives low
    logic       lock_n;
    logic       machine_check_error_n;

    // wired-or of active-low drivers
    assign lock_n = ~((dev_lock_oe & ~dev_lock_n_o) | (oth_lock_oe & ~oth_lock_n_o));
    assign machine_check_error_n = ~((dev_machine_check_error_n_oe & ~dev_machine_check_error_n_n_o)
                                   | (oth_machine_check_error_n_oe & ~oth_machine_check_error_n_n_o));

    modport dev (
        input  local_irq_pins,
        input  priority_agent_bus_request_n,
        input  lock_n,
        input  machine_check_error_n,
        output internal_fault_n,
        output dev_lock_n_o,
        output dev_lock_oe,
        output dev_machine_check_error_n_n_o,
        output dev_machine_check_error_n_oe
    );

    modport oth (
        output local_irq_pins,
        output priority_agent_bus_request_n,
        input  lock_n,
        input  machine_check_error_n,
        input  internal_fault_n,
        output oth_lock_n_o,
        output oth_lock_oe,
        output oth_machine_check_error_n_n_o,
        output oth_machine_check_error_n_oe
    );
endinterface

// *** verilog/fsbsb_dev.sv ***
// bus agent end: interrupt pin function, bus lock and machine check error
// Operation
// - controller off: pin0 maskable, pin1 non-maskable
// - interrupt pins accepted as asynchronous inputs
// - reset leaves local interrupt controller enabled
// - firmware selects pin function via controller config
// - drive lock for atomic issued transactions
// - hold lock from first start to last end
// - priority agent waits for lock release
// - machine check error reports unrecoverable non-protocol errors
// - every agent may drive machine check error
// - machine check error conditions configurable, global enable
// - internal error asserts machine check with fault
// - initiator asserts machine check on transaction error
// - observer asserts machine check; wired-or, clocked
`timescale 1ns/1ps
module fsbsb_dev (
    // clock and reset
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst_n,
    // pins
    fsbsb_if.dev                              bus,
    // interrupt controller configuration
    input  wire logic                         i_lic_cfg_we,
    input  wire logic                         i_lic_cfg_enable,
    output logic                              o_lic_enabled,
    // interrupt results
    output logic [fsbsb_pkg::IRQ_W-1:0]       o_local_irq,
    output logic                              o_maskable_irq_request,
    output logic                              o_nmi_pulse,
    // transaction sequencing
    input  wire logic                         i_txn_start,
    input  wire logic                         i_txn_locked,
    input  wire logic                         i_txn_end,
    input  wire logic                         i_txn_last,
    output logic                              o_lock_held,
    // machine check configuration
    input  wire logic                         i_mc_enable,
    input  wire logic                         i_mc_on_internal,
    input  wire logic                         i_mc_on_initiator,
    input  wire logic                         i_mc_on_observer,
    // error events
    input  wire logic                         i_internal_error,
    input  wire logic                         i_initiator_error,
    input  wire logic                         i_observed_error,
    output logic                              o_machine_check_error_n_seen,
    output logic                              o_internal_fault
);

    typedef enum logic [1:0] {
        LK_IDLE = 2'h1,
        LK_HELD = 2'h2
    } fsbsb_lock_state_type;

    // interrupt pin state
    logic [fsbsb_pkg::SYNC_STAGES-1:0] sync_ff [fsbsb_pkg::IRQ_W];
    logic [fsbsb_pkg::SYNC_STAGES-1:0] nxt_sync [fsbsb_pkg::IRQ_W];
    logic [fsbsb_pkg::IRQ_W-1:0]       irq_lvl_ff;
    logic [fsbsb_pkg::IRQ_W-1:0]       nxt_irq_lvl;
    logic                              lic_en_ff;
    logic                              nxt_lic_en;
    logic [fsbsb_pkg::IRQ_W-1:0]       local_irq_ff;
    logic [fsbsb_pkg::IRQ_W-1:0]       nxt_local_irq;
    logic                              maskable_ff;
    logic                              nxt_maskable;
    logic                              nmi_pulse_ff;
    logic                              nxt_nmi_pulse;

    // lock state
    fsbsb_lock_state_type              lock_state_ff;
    fsbsb_lock_state_type              nxt_lock_state;
    logic                              lock_oe_ff;
    logic                              nxt_lock_oe;

    // machine check state
    logic [fsbsb_pkg::MC_CNT_W-1:0]    mc_cnt_ff;
    logic [fsbsb_pkg::MC_CNT_W-1:0]    nxt_mc_cnt;
    logic                              mc_oe_ff;
    logic                              nxt_mc_oe;
    logic                              mc_low_ff;
    logic                              nxt_mc_low;
    logic                              mc_seen_ff;
    logic                              nxt_mc_seen;
    logic                              fault_ff;
    logic                              nxt_fault;
    logic                              mc_trigger;

    // interrupt pins: three flops per lane, level moves only when the
    // last two agree, so a metastable first stage never reaches logic
    always_comb
    begin
        for (int i = 0; i < fsbsb_pkg::IRQ_W; i++)
        begin
            nxt_sync[i] = {sync_ff[i][fsbsb_pkg::SYNC_STAGES-2:0],
                           bus.local_irq_pins[i]};
        end
        nxt_irq_lvl = irq_lvl_ff;
        for (int i = 0; i < fsbsb_pkg::IRQ_W; i++)
        begin
            if (sync_ff[i][1] == sync_ff[i][2])
            begin
                nxt_irq_lvl[i] = sync_ff[i][2];
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < fsbsb_pkg::IRQ_W; i++)
            begin
                sync_ff[i] <= '0;
            end
            irq_lvl_ff <= '0;
        end
        else
        begin
            for (int i = 0; i < fsbsb_pkg::IRQ_W; i++)
            begin
                sync_ff[i] <= nxt_sync[i];
            end
            irq_lvl_ff <= nxt_irq_lvl;
        end
    end

    // pin function: local pair while the controller is on, else
    // maskable level plus edge-detected non-maskable pulse
    always_comb
    begin
        nxt_lic_en = lic_en_ff;
        if (i_lic_cfg_we)
        begin
            nxt_lic_en = i_lic_cfg_enable;
        end
        nxt_local_irq = irq_lvl_ff & {fsbsb_pkg::IRQ_W{lic_en_ff}};
        nxt_maskable  = irq_lvl_ff[fsbsb_pkg::IRQ_MASKABLE] & ~lic_en_ff;
        // nmi is edge triggered, so one pulse per rising level
        nxt_nmi_pulse = ~lic_en_ff & nxt_irq_lvl[fsbsb_pkg::IRQ_NMI]
                      & ~irq_lvl_ff[fsbsb_pkg::IRQ_NMI];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            lic_en_ff    <= fsbsb_pkg::LIC_EN_RST;
            local_irq_ff <= '0;
            maskable_ff  <= 1'h0;
            nmi_pulse_ff <= 1'h0;
        end
        else
        begin
            lic_en_ff    <= nxt_lic_en;
            local_irq_ff <= nxt_local_irq;
            maskable_ff  <= nxt_maskable;
            nmi_pulse_ff <= nxt_nmi_pulse;
        end
    end

    // lock: raised on the first locked start, dropped only at the end
    // flagged last, so a sequence keeps the bus from the priority agent
    always_comb
    begin
        nxt_lock_state = lock_state_ff;
        case (lock_state_ff)
            LK_IDLE:
            begin
                if (i_txn_start && i_txn_locked)
                begin
                    nxt_lock_state = LK_HELD;
                end
            end
            LK_HELD:
            begin
                if (i_txn_end && i_txn_last)
                begin
                    nxt_lock_state = LK_IDLE;
                end
            end
            default:
            begin
                nxt_lock_state = LK_IDLE;
            end
        endcase
        nxt_lock_oe = (nxt_lock_state == LK_HELD);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            lock_state_ff <= LK_IDLE;
            lock_oe_ff    <= 1'h0;
        end
        else
        begin
            lock_state_ff <= nxt_lock_state;
            lock_oe_ff    <= nxt_lock_oe;
        end
    end

    // machine check: each enabled cause reloads a fixed-length drive,
    // launched from a flop so it only moves on a clock edge
    always_comb
    begin
        mc_trigger = i_mc_enable
                   & ((i_internal_error  & i_mc_on_internal)
                   |  (i_initiator_error & i_mc_on_initiator)
                   |  (i_observed_error  & i_mc_on_observer));
        if (mc_trigger)
        begin
            nxt_mc_cnt = fsbsb_pkg::MC_PULSE;
        end
        else if (mc_cnt_ff != fsbsb_pkg::MC_ZERO)
        begin
            nxt_mc_cnt = mc_cnt_ff - fsbsb_pkg::MC_ONE;
        end
        else
        begin
            nxt_mc_cnt = fsbsb_pkg::MC_ZERO;
        end
        nxt_mc_oe  = (nxt_mc_cnt != fsbsb_pkg::MC_ZERO);
        // internal fault is sticky until reset
        nxt_fault  = fault_ff | i_internal_error;
        // others may drive the shared wire; report only falling edges
        // that our own drive does not explain
        nxt_mc_low  = ~bus.machine_check_error_n;
        nxt_mc_seen = nxt_mc_low & ~mc_low_ff & ~mc_oe_ff;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            mc_cnt_ff  <= fsbsb_pkg::MC_ZERO;
            mc_oe_ff   <= 1'h0;
            mc_low_ff  <= 1'h0;
            mc_seen_ff <= 1'h0;
            fault_ff   <= 1'h0;
        end
        else
        begin
            mc_cnt_ff  <= nxt_mc_cnt;
            mc_oe_ff   <= nxt_mc_oe;
            mc_low_ff  <= nxt_mc_low;
            mc_seen_ff <= nxt_mc_seen;
            fault_ff   <= nxt_fault;
        end
    end

    // pin drivers: open-drain ends only ever pull low
    assign bus.dev_lock_n_o     = ~lock_oe_ff;
    assign bus.dev_lock_oe      = lock_oe_ff;
    assign bus.dev_machine_check_error_n_n_o    = ~mc_oe_ff;
    assign bus.dev_machine_check_error_n_oe     = mc_oe_ff;
    assign bus.internal_fault_n = ~fault_ff;

    // user side outputs
    assign o_lic_enabled          = lic_en_ff;
    assign o_local_irq            = local_irq_ff;
    assign o_maskable_irq_request = maskable_ff;
    assign o_nmi_pulse            = nmi_pulse_ff;
    assign o_lock_held            = lock_oe_ff;
    assign o_machine_check_error_n_seen           = mc_seen_ff;
    assign o_internal_fault       = fault_ff;

endmodule

// *** verilog/fsbsb_oth.sv ***
// system side end: drives interrupt pins, priority request, machine check
`timescale 1ns/1ps
module fsbsb_oth (
    // clock and reset
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst_n,
    // pins
    fsbsb_if.oth                              bus,
    // interrupt sources
    input  wire logic [fsbsb_pkg::IRQ_W-1:0]  i_irq_level,
    // priority agent requests
    input  wire logic                         i_prio_req,
    input  wire logic                         i_prio_release,
    output logic                              o_prio_grant,
    // machine check
    input  wire logic                         i_mc_enable,
    input  wire logic                         i_error_event,
    output logic                              o_machine_check_error_n_seen,
    output logic                              o_agent_fault
);

    typedef enum logic [2:0] {
        PA_IDLE = 3'h1,
        PA_WAIT = 3'h2,
        PA_OWN  = 3'h4
    } fsbsb_prio_state_type;

    fsbsb_prio_state_type              pa_state_ff;
    fsbsb_prio_state_type              nxt_pa_state;
    logic [fsbsb_pkg::IRQ_W-1:0]       irq_ff;
    logic [fsbsb_pkg::IRQ_W-1:0]       nxt_irq;
    logic                              req_n_ff;
    logic                              nxt_req_n;
    logic                              grant_ff;
    logic                              nxt_grant;
    logic [fsbsb_pkg::MC_CNT_W-1:0]    mc_cnt_ff;
    logic [fsbsb_pkg::MC_CNT_W-1:0]    nxt_mc_cnt;
    logic                              mc_oe_ff;
    logic                              nxt_mc_oe;
    logic                              mc_low_ff;
    logic                              nxt_mc_low;
    logic                              mc_seen_ff;
    logic                              nxt_mc_seen;
    logic                              fault_ff;
    logic                              nxt_fault;

    // priority agent: request, then own the bus only once lock is released
    always_comb
    begin
        nxt_pa_state = pa_state_ff;
        case (pa_state_ff)
            PA_IDLE:
            begin
                if (i_prio_req)
                begin
                    nxt_pa_state = PA_WAIT;
                end
            end
            PA_WAIT:
            begin
                if (bus.lock_n)
                begin
                    nxt_pa_state = PA_OWN;
                end
            end
            PA_OWN:
            begin
                if (i_prio_release)
                begin
                    nxt_pa_state = PA_IDLE;
                end
            end
            default:
            begin
                nxt_pa_state = PA_IDLE;
            end
        endcase
        nxt_req_n = (nxt_pa_state == PA_IDLE);
        nxt_grant = (nxt_pa_state == PA_OWN);
    end

    // machine check drive, same fixed length as the agent end
    always_comb
    begin
        if (i_mc_enable && i_error_event)
        begin
            nxt_mc_cnt = fsbsb_pkg::MC_PULSE;
        end
        else if (mc_cnt_ff != fsbsb_pkg::MC_ZERO)
        begin
            nxt_mc_cnt = mc_cnt_ff - fsbsb_pkg::MC_ONE;
        end
        else
        begin
            nxt_mc_cnt = fsbsb_pkg::MC_ZERO;
        end
        nxt_mc_oe   = (nxt_mc_cnt != fsbsb_pkg::MC_ZERO);
        nxt_mc_low  = ~bus.machine_check_error_n;
        nxt_mc_seen = nxt_mc_low & ~mc_low_ff & ~mc_oe_ff;
    end

    // pin levels pass through one flop so every driven pin except the tied-off lock pins is registered
    always_comb
    begin
        nxt_irq   = i_irq_level;
        nxt_fault = ~bus.internal_fault_n;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            pa_state_ff <= PA_IDLE;
            irq_ff      <= '0;
            req_n_ff    <= 1'h1;
            grant_ff    <= 1'h0;
            mc_cnt_ff   <= fsbsb_pkg::MC_ZERO;
            mc_oe_ff    <= 1'h0;
            mc_low_ff   <= 1'h0;
            mc_seen_ff  <= 1'h0;
            fault_ff    <= 1'h0;
        end
        else
        begin
            pa_state_ff <= nxt_pa_state;
            irq_ff      <= nxt_irq;
            req_n_ff    <= nxt_req_n;
            grant_ff    <= nxt_grant;
            mc_cnt_ff   <= nxt_mc_cnt;
            mc_oe_ff    <= nxt_mc_oe;
            mc_low_ff   <= nxt_mc_low;
            mc_seen_ff  <= nxt_mc_seen;
            fault_ff    <= nxt_fault;
        end
    end

    // pin drivers; this end never locks
    assign bus.local_irq_pins               = irq_ff;
    assign bus.priority_agent_bus_request_n = req_n_ff;
    assign bus.oth_lock_n_o                 = 1'h1;
    assign bus.oth_lock_oe                  = 1'h0;
    assign bus.oth_machine_check_error_n_n_o                = ~mc_oe_ff;
    assign bus.oth_machine_check_error_n_oe                 = mc_oe_ff;

    assign o_prio_grant  = grant_ff;
    assign o_machine_check_error_n_seen  = mc_seen_ff;
    assign o_agent_fault = fault_ff;

endmodule

// *** tb/fsbsb_asserts.sv ***
// concurrent checks on the sideband wires between the two ends
`timescale 1ns/1ps
module fsbsb_asserts (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // wires and drives
    input wire logic priority_agent_bus_request_n,
    input wire logic internal_fault_n,
    input wire logic dev_lock_n_o,
    input wire logic dev_lock_oe,
    input wire logic dev_machine_check_error_n_oe,
    input wire logic oth_machine_check_error_n_oe,
    input wire logic lock_n,
    input wire logic machine_check_error_n
);
    // one clock domain, so clocking and disable are given once
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // a held lock must reach the wire as a low level
    property p_lock_wire;
        dev_lock_oe |-> !dev_lock_n_o && !lock_n;
    endproperty
    a_lock_wire: assert property (p_lock_wire) else $error("lock drive not low");

    // a pending priority request cannot end while the bus is locked
    property p_prio_wait;
        !priority_agent_bus_request_n && !lock_n |=> !priority_agent_bus_request_n;
    endproperty
    a_prio_wait: assert property (p_prio_wait) else $error("request ended under lock");

    // own error drive lasts at least two bus clocks
    property p_mc_len;
        $rose(dev_machine_check_error_n_oe) |-> dev_machine_check_error_n_oe [*2];
    endproperty
    a_mc_len: assert property (p_mc_len) else $error("error drive too short");

    // own error drive never ends before its second cycle
    property p_mc_end;
        $fell(dev_machine_check_error_n_oe) |-> $past(dev_machine_check_error_n_oe, 2);
    endproperty
    a_mc_end: assert property (p_mc_end) else $error("error drive ended early");

    // the other agent's drive follows the same length
    property p_oth_len;
        $rose(oth_machine_check_error_n_oe) |-> oth_machine_check_error_n_oe [*2];
    endproperty
    a_oth_len: assert property (p_oth_len) else $error("other error drive short");

    // any drive pulls the shared error wire low
    property p_mc_wire;
        dev_machine_check_error_n_oe || oth_machine_check_error_n_oe |-> !machine_check_error_n;
    endproperty
    a_mc_wire: assert property (p_mc_wire) else $error("error wire not low");

    // internal fault stays until the next reset
    property p_fault_sticky;
        !internal_fault_n |=> !internal_fault_n;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared");

    // everything idle at the first edge after reset
    property p_rst_idle;
        $rose(i_rst_n) |-> internal_fault_n && lock_n && priority_agent_bus_request_n;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
endmodule

// *** tb/fsbsb_tb.sv ***
// testbench joining the bus agent end and the system side end
`timescale 1ns/1ps
module fsbsb_tb;
    logic       i_core_clk;
    logic       i_rst_n;
    logic       cfg_we, cfg_en, t_start, t_locked, t_end, t_last, mc_en;
    logic [2:0] mc_on, mc_err;
    logic [1:0] irq, loc_irq;
    logic       p_req, p_rel, o_mc_en, err_ev, lic_en, mask_req, nmi, grant, agent_fault;
    logic       lock_held, dev_seen, int_fault, oth_seen;
    int         error_cnt, samples_checked, low_cnt, dseen, oseen, nmi_cnt;

    fsbsb_if bus ();
    fsbsb_dev i_fsbsb_dev (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(bus),
        .i_lic_cfg_we(cfg_we), .i_lic_cfg_enable(cfg_en), .o_lic_enabled(lic_en),
        .o_local_irq(loc_irq), .o_maskable_irq_request(mask_req), .o_nmi_pulse(nmi),
        .i_txn_start(t_start), .i_txn_locked(t_locked), .i_txn_end(t_end),
        .i_txn_last(t_last), .o_lock_held(lock_held), .i_mc_enable(mc_en),
        .i_mc_on_internal(mc_on[0]), .i_mc_on_initiator(mc_on[1]),
        .i_mc_on_observer(mc_on[2]), .i_internal_error(mc_err[0]),
        .i_initiator_error(mc_err[1]), .i_observed_error(mc_err[2]),
        .o_machine_check_error_n_seen(dev_seen), .o_internal_fault(int_fault));
    fsbsb_oth i_fsbsb_oth (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(bus),
        .i_irq_level(irq), .i_prio_req(p_req), .i_prio_release(p_rel),
        .o_prio_grant(grant), .i_mc_enable(o_mc_en), .i_error_event(err_ev),
        .o_machine_check_error_n_seen(oth_seen), .o_agent_fault(agent_fault));
    fsbsb_asserts i_fsbsb_asserts (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .priority_agent_bus_request_n(bus.priority_agent_bus_request_n),
        .internal_fault_n(bus.internal_fault_n), .dev_lock_n_o(bus.dev_lock_n_o),
        .dev_lock_oe(bus.dev_lock_oe), .dev_machine_check_error_n_oe(bus.dev_machine_check_error_n_oe),
        .oth_machine_check_error_n_oe(bus.oth_machine_check_error_n_oe), .lock_n(bus.lock_n),
        .machine_check_error_n(bus.machine_check_error_n));

    // bus clock, 20 ns period
    initial
    begin
        i_core_clk = 1'h0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    // event counters; values seen here are those before the edge's updates
    always @(posedge i_core_clk)
    begin
        if (bus.machine_check_error_n === 1'h0) low_cnt++;
        if (dev_seen === 1'h1) dseen++;
        if (oth_seen === 1'h1) oseen++;
        if (nmi === 1'h1) nmi_cnt++;
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // inputs only ever change just after a falling edge
    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    task automatic clr;
        low_cnt = 0;
        dseen = 0;
        oseen = 0;
        nmi_cnt = 0;
    endtask

    // one error cause with a given enable setup; counts wire-low cycles
    task automatic mc(input logic [2:0] c, input logic g, input logic [2:0] p,
                      input int e_low, input int e_seen);
        clr();
        mc_en = g;
        mc_on = p;
        tick(1);
        mc_err = c;
        tick(1);
        mc_err = 3'h0;
        tick(6);
        chk("mc_low_cycles", e_low, low_cnt);
        chk("mc_seen_far", e_seen, oseen);
        chk("mc_seen_own", 8'h00, dseen);
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, far beyond the 116 cycles the tests need
    initial
    begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        {cfg_we, cfg_en, t_start, t_locked, t_end, t_last, mc_en, mc_on, mc_err} = '0;
        {irq, p_req, p_rel, o_mc_en, err_ev, i_rst_n} = '0;
        error_cnt = 0;
        samples_checked = 0;
        clr();
        tick(8);
        i_rst_n = 1'h1;
        tick(1);
        chk("lic_enabled", 8'h01, lic_en);
        chk("lock_wire", 8'h01, bus.lock_n);
        // controller on: pins are plain local inputs
        irq = 2'h3;
        tick(8);
        chk("local_irq", 8'h03, loc_irq);
        chk("maskable", 8'h00, mask_req);
        chk("nmi_count", 8'h00, nmi_cnt);
        irq = 2'h0;
        tick(8);
        // controller off: pin0 maskable, pin1 non-maskable
        cfg_we = 1'h1;
        tick(1);
        cfg_we = 1'h0;
        tick(2);
        chk("lic_enabled", 8'h00, lic_en);
        clr();
        irq = 2'h3;
        tick(3);
        chk("maskable_early", 8'h00, mask_req);
        tick(5);
        chk("maskable", 8'h01, mask_req);
        chk("local_irq_off", 8'h00, loc_irq);
        chk("nmi_count", 8'h01, nmi_cnt);
        // controller back on: pins return to the local pair
        cfg_en = 1'h1;
        cfg_we = 1'h1;
        tick(1);
        cfg_we = 1'h0;
        cfg_en = 1'h0;
        tick(2);
        chk("lic_reenabled", 8'h01, lic_en);
        chk("local_irq_back", 8'h03, loc_irq);
        chk("maskable_off", 8'h00, mask_req);
        // locked sequence with a priority request waiting on it
        {t_start, t_locked} = 2'h3;
        tick(1);
        t_start = 1'h0;
        tick(1);
        chk("lock_wire", 8'h00, bus.lock_n);
        chk("lock_held", 8'h01, lock_held);
        p_req = 1'h1;
        tick(1);
        p_req = 1'h0;
        tick(4);
        chk("grant_wait", 8'h00, grant);
        t_end = 1'h1;
        tick(1);
        t_end = 1'h0;
        tick(2);
        chk("lock_mid", 8'h00, bus.lock_n);
        {t_end, t_last} = 2'h3;
        tick(1);
        {t_end, t_last} = 2'h0;
        chk("lock_released", 8'h01, bus.lock_n);
        chk("lock_held_off", 8'h00, lock_held);
        tick(2);
        chk("grant", 8'h01, grant);
        p_rel = 1'h1;
        tick(1);
        p_rel = 1'h0;
        tick(2);
        chk("grant_dropped", 8'h00, grant);
        {t_start, t_locked} = 2'h2;
        tick(1);
        t_start = 1'h0;
        tick(2);
        chk("unlocked_start", 8'h01, bus.lock_n);
        // machine check causes against the enable options
        mc(3'h2, 1'h1, 3'h7, 2, 1);
        mc(3'h4, 1'h1, 3'h7, 2, 1);
        mc(3'h2, 1'h0, 3'h7, 0, 0);
        mc(3'h4, 1'h1, 3'h3, 0, 0);
        chk("fault_idle", 8'h01, bus.internal_fault_n);
        mc(3'h1, 1'h0, 3'h7, 0, 0);
        chk("fault_wire", 8'h00, bus.internal_fault_n);
        chk("internal_fault", 8'h01, int_fault);
        chk("agent_fault", 8'h01, agent_fault);
        mc(3'h1, 1'h1, 3'h1, 2, 1);
        // the other agent drives the shared error wire
        clr();
        o_mc_en = 1'h1;
        err_ev = 1'h1;
        tick(1);
        err_ev = 1'h0;
        tick(6);
        chk("oth_low_cycles", 8'h02, low_cnt);
        chk("dev_seen", 8'h01, dseen);
        chk("oth_seen_own", 8'h00, oseen);
        // a second reset clears the sticky fault and leaves the controller enabled
        i_rst_n = 1'h0;
        tick(2);
        i_rst_n = 1'h1;
        tick(1);
        chk("fault_after_rst", 8'h01, bus.internal_fault_n);
        chk("int_fault_after_rst", 8'h00, int_fault);
        chk("lic_after_rst", 8'h01, lic_en);
        tally_and_finish();
    end
endmodule
